// >>> core/bsf_cfg.svh
// offsets, field positions, reset values and cycle counts of the flow unit
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH

// register byte offsets
`define BSF_OFF_INSN 8'h00
`define BSF_OFF_OPER 8'h04
`define BSF_OFF_ZPTR 8'h08
`define BSF_OFF_STACK 8'h0C
`define BSF_OFF_PC 8'h10
`define BSF_OFF_STATUS_FLAGS_REGISTER 8'h14
`define BSF_OFF_STAT 8'h18
`define BSF_OFF_PUSH 8'h1C
`define BSF_OFF_IO 8'h20

// instruction word fields
`define BSF_OP_MSB 5
`define BSF_OP_LSB 0
`define BSF_BIT_MSB 8
`define BSF_BIT_LSB 6
`define BSF_K_MSB 31
`define BSF_K_LSB 16

// operand word fields
`define BSF_RD_LSB 0
`define BSF_RR_LSB 8
`define BSF_IOV_LSB 16
`define BSF_TWO_WORD_BIT 24

// status flag positions
`define BSF_FLAG_C 0
`define BSF_FLAG_Z 1
`define BSF_FLAG_N 2
`define BSF_FLAG_V 3
`define BSF_FLAG_S 4
`define BSF_FLAG_H 5
`define BSF_FLAG_T 6
`define BSF_FLAG_I 7

// reset values
`define BSF_RST_PC 16'h0000
`define BSF_RST_STATUS_FLAGS_REGISTER 8'h00

// cycle counts
`define BSF_CYC_ONE 3'h1
`define BSF_CYC_SKIP_SHORT 3'h2
`define BSF_CYC_SKIP_LONG 3'h3
`define BSF_CYC_BR_TAKEN 3'h2
`define BSF_CYC_GOTO_REL 3'h2
`define BSF_CYC_GOTO_Z 3'h2
`define BSF_CYC_GOTO_ABS 3'h3
`define BSF_CYC_INVOKE_REL 3'h3
`define BSF_CYC_INVOKE_Z 3'h3
`define BSF_CYC_INVOKE_ABS 3'h4
`define BSF_CYC_EXIT 3'h4
`define BSF_CYC_IO_BIT 3'h2

`endif

// >>> core/bsf_pkg.sv
// types of the flow unit
package bsf_pkg;
    typedef enum logic [5:0] {
        BSF_GOTO_REL = 6'h00, BSF_GOTO_Z = 6'h01, BSF_GOTO_ABS = 6'h02,
        BSF_INVOKE_REL = 6'h03, BSF_INVOKE_Z = 6'h04,
        BSF_INVOKE_ABS = 6'h05, BSF_SUB_EXIT = 6'h06,
        BSF_IRQ_EXIT = 6'h07, BSF_CMP_SKIP_EQ = 6'h08,
        BSF_CMP_REGS = 6'h09, BSF_CMP_BORROW = 6'h0A,
        BSF_CMP_IMM = 6'h0B, BSF_SKIP_REG_ZERO = 6'h0C,
        BSF_SKIP_REG_ONE = 6'h0D, BSF_SKIP_IO_ZERO = 6'h0E,
        BSF_SKIP_IO_ONE = 6'h0F, BSF_BR_FLAG_ONE = 6'h10,
        BSF_BR_FLAG_ZERO = 6'h11, BSF_BR_EQ = 6'h12, BSF_BR_NE = 6'h13,
        BSF_BR_C_ONE = 6'h14, BSF_BR_C_ZERO = 6'h15, BSF_BR_U_GE = 6'h16,
        BSF_BR_U_LT = 6'h17, BSF_BR_NEG = 6'h18, BSF_BR_POS = 6'h19,
        BSF_BR_S_GE = 6'h1A, BSF_BR_S_LT = 6'h1B, BSF_BR_H_ONE = 6'h1C,
        BSF_BR_H_ZERO = 6'h1D, BSF_BR_T_ONE = 6'h1E, BSF_BR_T_ZERO = 6'h1F,
        BSF_BR_V_ONE = 6'h20, BSF_BR_V_ZERO = 6'h21,
        BSF_BR_IRQ_ON = 6'h22, BSF_BR_IRQ_OFF = 6'h23,
        BSF_IO_SET = 6'h24, BSF_IO_CLR = 6'h25
    } bsf_op_type;
endpackage

// >>> core/bsf_core.sv
// program flow unit: jumps, calls, returns, compares, skips, branches
// Functional notes
// - indirect jump loads Z, two cycles
// - indirect call pushes return, loads Z, three
// - compare-skip-equal skips next, one/two/three cycles
// - compares set Z N V C H, one cycle
// - skip when register bit is zero
// - skip when register bit is one
// - skip when I/O bit is zero
// - skip when I/O bit is one
// - branch when selected flag one, pc+k+1
// - branch when selected flag zero
// - carry-one and unsigned-lower test carry one
// - carry-zero and unsigned-ge test carry zero
// - negative/positive branches test N flag
// - signed ge/lt test N xor V
// - half-carry branches test H flag
// - transfer-bit branches test T flag
// - overflow branches test V flag
// - interrupt branches test I flag
// - I/O bit force one, two cycles
// - I/O bit force zero, two cycles
`include "bsf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module bsf_core #(
    parameter int PC_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] prog_counter,
    output logic exec_busy
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] insn_q, oper_q;
    logic [15:0] zptr_q, stack_q;
    logic [PC_W-1:0] pc_q, pc_d, push_q, push_d;
    logic [7:0] status_flags_register_q, status_flags_register_d, io_q, io_d;
    logic [2:0] cyc_q, cyc_d, cnt_q;
    logic pready_q, pslverr_q, exec_q;
    logic [31:0] prdata_q;
    logic acc, done, wr, start, busy;

    assign acc = psel & penable;
    assign done = acc & pready_q;
    assign wr = done & pwrite;
    assign busy = cnt_q != 3'h0;
    assign start = wr & (paddr == `BSF_OFF_INSN) & ~busy;

    // ----------------------------------------------------------------
    // decode of the written instruction word
    // ----------------------------------------------------------------
    bsf_pkg::bsf_op_type op;
    logic [2:0] bsel;
    logic [15:0] k;
    logic [7:0] rd, rr, iov, rr_eff, res;
    logic [8:0] diff;
    logic two_word, is_br, cond, cin, bit_v;
    logic [PC_W-1:0] pc_next, pc_rel, pc_skip;
    logic [2:0] cyc_skip;

    always_comb begin
        op = bsf_pkg::bsf_op_type'(pwdata[`BSF_OP_MSB:`BSF_OP_LSB]);
        bsel = pwdata[`BSF_BIT_MSB:`BSF_BIT_LSB];
        k = pwdata[`BSF_K_MSB:`BSF_K_LSB];
        rd = oper_q[`BSF_RD_LSB +: 8];
        rr = oper_q[`BSF_RR_LSB +: 8];
        iov = oper_q[`BSF_IOV_LSB +: 8];
        two_word = oper_q[`BSF_TWO_WORD_BIT];
        pc_next = pc_q + PC_W'(1);
        pc_rel = pc_q + PC_W'($signed(k)) + PC_W'(1);
        pc_skip = pc_q + (two_word ? PC_W'(3) : PC_W'(2));
        cyc_skip = two_word ? `BSF_CYC_SKIP_LONG : `BSF_CYC_SKIP_SHORT;
        rr_eff = (op == bsf_pkg::BSF_CMP_IMM) ? k[7:0] : rr;
        cin = (op == bsf_pkg::BSF_CMP_BORROW) & status_flags_register_q[`BSF_FLAG_C];
        diff = {1'b0, rd} - {1'b0, rr_eff} - {8'h00, cin};
        res = diff[7:0];
        bit_v = rr[bsel];
        is_br = 1'b1;
        cond = 1'b0;
        case (op)
            bsf_pkg::BSF_BR_FLAG_ONE: cond = status_flags_register_q[bsel];
            bsf_pkg::BSF_BR_FLAG_ZERO: cond = ~status_flags_register_q[bsel];
            bsf_pkg::BSF_BR_EQ: cond = status_flags_register_q[`BSF_FLAG_Z];
            bsf_pkg::BSF_BR_NE: cond = ~status_flags_register_q[`BSF_FLAG_Z];
            bsf_pkg::BSF_BR_C_ONE,
            bsf_pkg::BSF_BR_U_LT: cond = status_flags_register_q[`BSF_FLAG_C];
            bsf_pkg::BSF_BR_C_ZERO,
            bsf_pkg::BSF_BR_U_GE: cond = ~status_flags_register_q[`BSF_FLAG_C];
            bsf_pkg::BSF_BR_NEG: cond = status_flags_register_q[`BSF_FLAG_N];
            bsf_pkg::BSF_BR_POS: cond = ~status_flags_register_q[`BSF_FLAG_N];
            bsf_pkg::BSF_BR_S_GE:
                cond = ~(status_flags_register_q[`BSF_FLAG_N] ^ status_flags_register_q[`BSF_FLAG_V]);
            bsf_pkg::BSF_BR_S_LT:
                cond = status_flags_register_q[`BSF_FLAG_N] ^ status_flags_register_q[`BSF_FLAG_V];
            bsf_pkg::BSF_BR_H_ONE: cond = status_flags_register_q[`BSF_FLAG_H];
            bsf_pkg::BSF_BR_H_ZERO: cond = ~status_flags_register_q[`BSF_FLAG_H];
            bsf_pkg::BSF_BR_T_ONE: cond = status_flags_register_q[`BSF_FLAG_T];
            bsf_pkg::BSF_BR_T_ZERO: cond = ~status_flags_register_q[`BSF_FLAG_T];
            bsf_pkg::BSF_BR_V_ONE: cond = status_flags_register_q[`BSF_FLAG_V];
            bsf_pkg::BSF_BR_V_ZERO: cond = ~status_flags_register_q[`BSF_FLAG_V];
            bsf_pkg::BSF_BR_IRQ_ON: cond = status_flags_register_q[`BSF_FLAG_I];
            bsf_pkg::BSF_BR_IRQ_OFF: cond = ~status_flags_register_q[`BSF_FLAG_I];
            default: is_br = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // outcome: next pc, flags, cycles, pushed address, I/O value
    // ----------------------------------------------------------------
    always_comb begin
        pc_d = pc_next;
        status_flags_register_d = status_flags_register_q;
        cyc_d = `BSF_CYC_ONE;
        push_d = push_q;
        io_d = iov;
        if (is_br) begin
            if (cond) begin
                pc_d = pc_rel;
                cyc_d = `BSF_CYC_BR_TAKEN;
            end
        end else begin
            case (op)
                bsf_pkg::BSF_GOTO_REL: begin
                    pc_d = pc_rel;
                    cyc_d = `BSF_CYC_GOTO_REL;
                end
                bsf_pkg::BSF_GOTO_Z: begin
                    pc_d = PC_W'(zptr_q);
                    cyc_d = `BSF_CYC_GOTO_Z;
                end
                bsf_pkg::BSF_GOTO_ABS: begin
                    pc_d = PC_W'(k);
                    cyc_d = `BSF_CYC_GOTO_ABS;
                end
                bsf_pkg::BSF_INVOKE_REL: begin
                    push_d = pc_next;
                    pc_d = pc_rel;
                    cyc_d = `BSF_CYC_INVOKE_REL;
                end
                bsf_pkg::BSF_INVOKE_Z: begin
                    push_d = pc_next;
                    pc_d = PC_W'(zptr_q);
                    cyc_d = `BSF_CYC_INVOKE_Z;
                end
                bsf_pkg::BSF_INVOKE_ABS: begin
                    push_d = pc_q + PC_W'(2);
                    pc_d = PC_W'(k);
                    cyc_d = `BSF_CYC_INVOKE_ABS;
                end
                bsf_pkg::BSF_SUB_EXIT: begin
                    pc_d = PC_W'(stack_q);
                    cyc_d = `BSF_CYC_EXIT;
                end
                bsf_pkg::BSF_IRQ_EXIT: begin
                    pc_d = PC_W'(stack_q);
                    status_flags_register_d[`BSF_FLAG_I] = 1'b1;
                    cyc_d = `BSF_CYC_EXIT;
                end
                bsf_pkg::BSF_CMP_SKIP_EQ: begin
                    if (rd == rr) begin
                        pc_d = pc_skip;
                        cyc_d = cyc_skip;
                    end
                end
                bsf_pkg::BSF_CMP_REGS, bsf_pkg::BSF_CMP_BORROW,
                bsf_pkg::BSF_CMP_IMM: begin
                    status_flags_register_d[`BSF_FLAG_N] = res[7];
                    status_flags_register_d[`BSF_FLAG_V] = (rd[7] & ~rr_eff[7] & ~res[7])
                        | (~rd[7] & rr_eff[7] & res[7]);
                    status_flags_register_d[`BSF_FLAG_S] = status_flags_register_d[`BSF_FLAG_N]
                        ^ status_flags_register_d[`BSF_FLAG_V];
                    status_flags_register_d[`BSF_FLAG_C] = (~rd[7] & rr_eff[7])
                        | (rr_eff[7] & res[7]) | (res[7] & ~rd[7]);
                    status_flags_register_d[`BSF_FLAG_H] = (~rd[3] & rr_eff[3])
                        | (rr_eff[3] & res[3]) | (res[3] & ~rd[3]);
                    if (op == bsf_pkg::BSF_CMP_BORROW) begin
                        status_flags_register_d[`BSF_FLAG_Z] = (res == 8'h00)
                            & status_flags_register_q[`BSF_FLAG_Z];
                    end else begin
                        status_flags_register_d[`BSF_FLAG_Z] = res == 8'h00;
                    end
                end
                bsf_pkg::BSF_SKIP_REG_ZERO: begin
                    if (~bit_v) begin
                        pc_d = pc_skip;
                        cyc_d = cyc_skip;
                    end
                end
                bsf_pkg::BSF_SKIP_REG_ONE: begin
                    if (bit_v) begin
                        pc_d = pc_skip;
                        cyc_d = cyc_skip;
                    end
                end
                bsf_pkg::BSF_SKIP_IO_ZERO: begin
                    if (~iov[bsel]) begin
                        pc_d = pc_skip;
                        cyc_d = cyc_skip;
                    end
                end
                bsf_pkg::BSF_SKIP_IO_ONE: begin
                    if (iov[bsel]) begin
                        pc_d = pc_skip;
                        cyc_d = cyc_skip;
                    end
                end
                bsf_pkg::BSF_IO_SET: begin
                    io_d[bsel] = 1'b1;
                    cyc_d = `BSF_CYC_IO_BIT;
                end
                bsf_pkg::BSF_IO_CLR: begin
                    io_d[bsel] = 1'b0;
                    cyc_d = `BSF_CYC_IO_BIT;
                end
                default: cyc_d = `BSF_CYC_ONE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // execution state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= PC_W'(`BSF_RST_PC);
            status_flags_register_q <= `BSF_RST_STATUS_FLAGS_REGISTER;
            push_q <= '0;
            io_q <= 8'h00;
            cyc_q <= 3'h0;
            insn_q <= 32'h00000000;
        end else if (start) begin
            pc_q <= pc_d;
            status_flags_register_q <= status_flags_register_d;
            push_q <= push_d;
            io_q <= io_d;
            cyc_q <= cyc_d;
            insn_q <= pwdata;
        end else if (wr && paddr == `BSF_OFF_PC) begin
            pc_q <= pwdata[PC_W-1:0];
        end else if (wr && paddr == `BSF_OFF_STATUS_FLAGS_REGISTER) begin
            status_flags_register_q <= pwdata[7:0];
        end
    end

    // remaining cycles of the running instruction, busy flag kept in a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
            exec_q <= 1'b0;
        end else if (start) begin
            cnt_q <= cyc_d - 3'h1;
            exec_q <= cyc_d != `BSF_CYC_ONE;
        end else if (busy) begin
            cnt_q <= cnt_q - 3'h1;
            exec_q <= cnt_q != 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // operand registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oper_q <= 32'h00000000;
            zptr_q <= 16'h0000;
            stack_q <= 16'h0000;
        end else if (wr && ~busy) begin
            if (paddr == `BSF_OFF_OPER) begin
                oper_q <= {7'h00, pwdata[24:0]};
            end else if (paddr == `BSF_OFF_ZPTR) begin
                zptr_q <= pwdata[15:0];
            end else if (paddr == `BSF_OFF_STACK) begin
                stack_q <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    logic [31:0] rdata;
    logic hit;

    always_comb begin
        rdata = 32'h00000000;
        hit = 1'b1;
        if (paddr == `BSF_OFF_INSN) begin
            rdata = insn_q;
        end else if (paddr == `BSF_OFF_OPER) begin
            rdata = oper_q;
        end else if (paddr == `BSF_OFF_ZPTR) begin
            rdata = {16'h0000, zptr_q};
        end else if (paddr == `BSF_OFF_STACK) begin
            rdata = {16'h0000, stack_q};
        end else if (paddr == `BSF_OFF_PC) begin
            rdata = 32'(pc_q);
        end else if (paddr == `BSF_OFF_STATUS_FLAGS_REGISTER) begin
            rdata = {24'h000000, status_flags_register_q};
        end else if (paddr == `BSF_OFF_STAT) begin
            rdata = {23'h000000, busy, 5'h00, cyc_q};
        end else if (paddr == `BSF_OFF_PUSH) begin
            rdata = 32'(push_q);
        end else if (paddr == `BSF_OFF_IO) begin
            rdata = {24'h000000, io_q};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit;
            prdata_q <= (acc & ~pready_q & ~pwrite) ? rdata : 32'h00000000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prog_counter = pc_q;
    assign exec_busy = exec_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_goto_z;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_GOTO_Z |=>
            pc_q == PC_W'($past(zptr_q)) && cnt_q == 3'h1
            && status_flags_register_q == $past(status_flags_register_q);
    endproperty
    a_goto_z: assert property (p_goto_z)
        else $error("indirect jump target or timing wrong");

    property p_invoke_z;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_INVOKE_Z |=>
            push_q == $past(pc_q) + PC_W'(1) && cnt_q == 3'h2
            ##1 cnt_q == 3'h1 ##1 cnt_q == 3'h0;
    endproperty
    a_invoke_z: assert property (p_invoke_z)
        else $error("indirect call push or timing wrong");

    property p_skip_eq;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_CMP_SKIP_EQ && rd != rr |=>
            pc_q == $past(pc_q) + PC_W'(1) && cnt_q == 3'h0;
    endproperty
    a_skip_eq: assert property (p_skip_eq)
        else $error("unequal compare-skip must not skip");

    property p_cmp_zero;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_CMP_REGS |=>
            status_flags_register_q[`BSF_FLAG_Z] == ($past(rd) == $past(rr))
            && cnt_q == 3'h0 && pc_q == $past(pc_q) + PC_W'(1);
    endproperty
    a_cmp_zero: assert property (p_cmp_zero)
        else $error("compare zero flag wrong");

    property p_skip_reg_one;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_SKIP_REG_ONE && bit_v && two_word |=>
            pc_q == $past(pc_q) + PC_W'(3) && cyc_q == 3'h3;
    endproperty
    a_skip_reg_one: assert property (p_skip_reg_one)
        else $error("skip over two-word instruction wrong");

    property p_branch_taken;
        @(posedge clk) disable iff (!nrst)
        start && is_br && cond |=>
            pc_q == $past(pc_rel) && cyc_q == 3'h2 ##1 !exec_busy;
    endproperty
    a_branch_taken: assert property (p_branch_taken)
        else $error("taken branch target or timing wrong");

    property p_branch_not;
        @(posedge clk) disable iff (!nrst)
        start && is_br && !cond |=>
            pc_q == $past(pc_q) + PC_W'(1) && !exec_busy;
    endproperty
    a_branch_not: assert property (p_branch_not)
        else $error("untaken branch must fall through in one cycle");

    property p_io_set;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_IO_SET |=>
            io_q[$past(bsel)] && status_flags_register_q == $past(status_flags_register_q) && cyc_q == 3'h2;
    endproperty
    a_io_set: assert property (p_io_set)
        else $error("io bit set wrong");

    property p_irq_exit;
        @(posedge clk) disable iff (!nrst)
        start && op == bsf_pkg::BSF_IRQ_EXIT |=>
            status_flags_register_q[`BSF_FLAG_I] && pc_q == PC_W'($past(stack_q))
            ##3 !exec_busy;
    endproperty
    a_irq_exit: assert property (p_irq_exit)
        else $error("interrupt exit wrong");

endmodule // bsf_core

`default_nettype wire

// >>> dv/branch_skip_flow_control_tb.sv
// self-checking bench of the program flow unit
`timescale 1ns/10ps
`default_nettype none
`include "bsf_cfg.svh"

module branch_skip_flow_control_tb;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, exec_busy, er;
    logic [7:0] paddr = 8'h00, status_flags_register_m, io_m;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, oper_m, insn;
    logic [31:0] lfsr = 32'h0000437F;
    logic [15:0] prog_counter, pc_m, z_m, stk_m, nxt;
    logic [15:0] push_m = 16'h0000;
    int err_count = 0, comparisons = 0, ticks = 0, cyc_m, n, op;
    int cyc_t [0:7] = '{2, 2, 3, 3, 3, 4, 4, 4};

    bsf_core dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_counter(prog_counter),
        .exec_busy(exec_busy));

    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            err_count++;
            $display("FAIL %0t run did not finish in time", $time);
            final_report();
        end
    end

    // one transfer: setup, access held until pready seen high
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w >= 16) chk(32'h0, 32'h1, "no ready");
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
        input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    task automatic model(input int op, input int b, input logic [15:0] k);
        logic [7:0] d, r, s, iv;
        logic f, sk;
        d = oper_m[7:0];
        r = (op == 11) ? k[7:0] : oper_m[15:8];
        iv = oper_m[23:16];
        io_m = iv;
        cyc_m = (op < 8) ? cyc_t[op] : ((op == 36 || op == 37) ? 2 : 1);
        nxt = pc_m + 16'h1;
        sk = 1'b0;
        f = status_flags_register_m[b];
        case (op)
            0, 3: nxt = pc_m + k + 16'h1;
            1, 4: nxt = z_m;
            2, 5: nxt = k;
            6, 7: nxt = stk_m;
            8: sk = (d == r);
            12: sk = !oper_m[8 + b];
            13: sk = oper_m[8 + b];
            14: sk = !iv[b];
            15: sk = iv[b];
            36: io_m[b] = 1'b1;
            37: io_m[b] = 1'b0;
            default: ;
        endcase
        if (op == 3 || op == 4) push_m = pc_m + 16'h1;
        if (op == 5) push_m = pc_m + 16'h2;
        if (op == 7) status_flags_register_m[7] = 1'b1;
        if (op >= 9 && op <= 11) begin
            s = d - r - ((op == 10) ? status_flags_register_m[0] : 1'b0);
            status_flags_register_m[0] = (~d[7] & r[7]) | (r[7] & s[7]) | (s[7] & ~d[7]);
            status_flags_register_m[1] = (s == 8'h00) & (op != 10 | status_flags_register_m[1]);
            status_flags_register_m[2] = s[7];
            status_flags_register_m[3] = (d[7] & ~r[7] & ~s[7]) | (~d[7] & r[7] & s[7]);
            status_flags_register_m[4] = status_flags_register_m[2] ^ status_flags_register_m[3];
            status_flags_register_m[5] = (~d[3] & r[3]) | (r[3] & s[3]) | (s[3] & ~d[3]);
        end
        if (op >= 16 && op <= 35) begin
            case (op)
                18, 19: f = status_flags_register_m[1];
                20, 21: f = status_flags_register_m[0];
                22, 23: f = !status_flags_register_m[0];
                24, 25: f = status_flags_register_m[2];
                26, 27: f = !(status_flags_register_m[2] ^ status_flags_register_m[3]);
                28, 29: f = status_flags_register_m[5];
                30, 31: f = status_flags_register_m[6];
                32, 33: f = status_flags_register_m[3];
                34, 35: f = status_flags_register_m[7];
                default: ;
            endcase
            if (f ^ op[0]) begin
                nxt = pc_m + k + 16'h1;
                cyc_m = 2;
            end
        end
        if (sk) begin
            nxt = pc_m + (oper_m[24] ? 16'h3 : 16'h2);
            cyc_m = oper_m[24] ? 3 : 2;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 8'h10; a <= 8'h20; a += 4) begin
            rdchk(a[7:0], 32'h0, "reset value");
        end
        rdchk(8'h40, 32'h0, "unmapped data");
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset and map done");
        // every code four times, operands and flags random
        for (int i = 0; i < 160; i++) begin
            op = i % 40;
            insn = (rnd() & 32'hFFFF01C0) | 32'(op);
            oper_m = rnd();
            if (i[3]) oper_m[15:8] = oper_m[7:0];
            // last round: bit-one skip over a two-word instruction
            if (op == 13 && i >= 120) begin
                oper_m[24] = 1'b1;
                oper_m[8 + int'(insn[8:6])] = 1'b1;
            end
            {z_m, stk_m} = rnd();
            {pc_m, status_flags_register_m, io_m} = rnd();
            apb(1'b1, `BSF_OFF_STATUS_FLAGS_REGISTER, {24'h0, status_flags_register_m});
            apb(1'b1, `BSF_OFF_PC, {16'h0, pc_m});
            apb(1'b1, `BSF_OFF_ZPTR, {16'h0, z_m});
            apb(1'b1, `BSF_OFF_STACK, {16'h0, stk_m});
            apb(1'b1, `BSF_OFF_OPER, oper_m);
            model(op, int'(insn[8:6]), insn[31:16]);
            apb(1'b1, `BSF_OFF_INSN, insn);
            #1;
            n = 0;
            while (exec_busy === 1'b1 && n < 8) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(n, cyc_m - 1, "busy cycles");
            chk({16'h0, prog_counter}, {16'h0, nxt}, "pc port");
            rdchk(`BSF_OFF_PC, {16'h0, nxt}, "pc");
            rdchk(`BSF_OFF_STATUS_FLAGS_REGISTER, {24'h0, status_flags_register_m}, "flags");
            rdchk(`BSF_OFF_STAT, 32'(cyc_m), "cycles");
            rdchk(`BSF_OFF_PUSH, {16'h0, push_m}, "push");
            rdchk(`BSF_OFF_IO, {24'h0, io_m}, "io");
        end
        $display("test flow codes done");
        final_report();
    end
endmodule // branch_skip_flow_control_tb

`default_nettype wire
